// ### hw/pack_presence_and_bus_watch.sv
// pack presence, bus watch, bus master, oscillator pick and charge counter
`timescale 1ns/1ps
module pack_presence_and_bus_watch
    import pw_pkg::*;
#(
    parameter int TOUT_P = TOUT_CYC,
    parameter int SEXT_P = SEXT_CYC,
    parameter int SEC_P = SEC_CYC
)
(
    input logic clk_i,
    input logic nrst_i,
    input logic [7:0] wb_adr_i,
    input logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input logic wb_we_i,
    input logic [3:0] wb_sel_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    output logic wb_ack_o,
    output logic irq_o,
    input logic bus_clock_line_i,
    output logic bus_clock_line_o,
    output logic bus_clock_line_oe_o,
    input logic bus_data_line_i,
    output logic bus_data_line_o,
    output logic bus_data_line_oe_o,
    input logic pack_present_input_n_i,
    output logic presence_bias_output_o,
    input logic osc_set_resistor_pin_i,
    output logic osc_internal_en_o,
    output logic osc_crystal_en_o,
    output logic chg_fet_en_o,
    output logic dsg_fet_en_o,
    output logic precharge_fet_en_o,
    input logic signed [15:0] cc_sample_i,
    input logic cc_valid_i,
    output logic adc_start_o,
    output logic cc_charge_o,
    output logic cc_discharge_o
);
    localparam int TW = $clog2(TOUT_P + 1);
    localparam int XW = $clog2(SEXT_P + 1);
    localparam int SW = $clog2(SEC_P);
    localparam int IW = $clog2(IDLE_CYC + 1);
    // cycles a released clock still reads low through the synchroniser
    localparam int LAG = 2;

    // byte lanes to bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic scl_d_ff;
    logic sda_d_ff;
    wire logic scl = s2_ff[0];
    wire logic sda = s2_ff[1];
    wire logic pack_present_input_n = s2_ff[2];
    wire logic osc_set_resistor_pin = s2_ff[3];

    // two stages for every pin, then one delay for edges
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            s1_ff <= 4'hF;
            s2_ff <= 4'hF;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            s1_ff <= {osc_set_resistor_pin_i, pack_present_input_n_i,
                      bus_data_line_i, bus_clock_line_i};
            s2_ff <= s1_ff;
            scl_d_ff <= scl;
            sda_d_ff <= sda;
        end
    end

    // ****************************************
    // bus watch
    // ****************************************
    logic [TW-1:0] low_cnt_ff;
    logic [IW-1:0] hi_cnt_ff;
    logic in_msg_ff;
    logic wait_start_ff;
    logic [XW-1:0] ext_cnt_ff;
    mst_state_e mst_st_ff;
    wire logic start_det = scl && scl_d_ff && sda_d_ff && !sda;
    wire logic stop_det = scl && scl_d_ff && !sda_d_ff && sda;
    wire logic timeout_hit = in_msg_ff && !scl && low_cnt_ff == TW'(TOUT_P);
    wire logic idle_hit = in_msg_ff && scl && hi_cnt_ff == IW'(IDLE_CYC);
    wire logic sext_hit = mst_st_ff == M_HIGH && ext_cnt_ff == XW'(SEXT_P);
    wire logic abort = timeout_hit || idle_hit || sext_hit;

    // low and high time counters, saturating at their limits
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i || scl)
            low_cnt_ff <= '0;
        else if (low_cnt_ff != TW'(TOUT_P))
            low_cnt_ff <= low_cnt_ff + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i || !scl || start_det)
            hi_cnt_ff <= '0;
        else if (hi_cnt_ff != IW'(IDLE_CYC))
            hi_cnt_ff <= hi_cnt_ff + 1'b1;
    end

    // message framing; a start wins over an abort in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            in_msg_ff <= 1'b0;
            wait_start_ff <= 1'b0;
        end
        else
        begin
            in_msg_ff <= start_det || (in_msg_ff && !stop_det && !abort);
            wait_start_ff <= !start_det && (abort || wait_start_ff);
        end
    end

    // ****************************************
    // bus master
    // ****************************************
    logic [7:0] half_cnt_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] mbyte_ff;
    logic scl_oe_ff;
    logic sda_oe_ff;
    logic nack_ff;
    logic go;
    mst_state_e nxt_st;
    logic [7:0] nxt_half;
    logic [3:0] nxt_bit;
    logic [7:0] nxt_shift;
    logic nxt_scl_oe;
    logic nxt_sda_oe;
    logic nxt_nack;
    logic [XW-1:0] nxt_ext;
    logic mdone;
    wire logic half_end = half_cnt_ff == 8'(MAS_HALF_CYC - 1);
    wire logic mst_busy = mst_st_ff != M_IDLE;

    // start, eight data bits, ack slot, stop at a fixed half period
    always_comb
    begin
        nxt_st = mst_st_ff;
        nxt_half = half_cnt_ff + 1'b1;
        nxt_bit = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_scl_oe = scl_oe_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_nack = nack_ff;
        nxt_ext = ext_cnt_ff;
        mdone = 1'b0;
        case (mst_st_ff)
            M_IDLE:
            begin
                nxt_half = '0;
                nxt_ext = '0;
                if (go)
                begin
                    nxt_st = M_START;
                    nxt_sda_oe = 1'b1;
                    nxt_shift = wb_dat_i[7:0];
                    nxt_bit = '0;
                end
            end
            M_START:
            begin
                if (half_end)
                begin
                    nxt_half = '0;
                    nxt_scl_oe = 1'b1;
                    nxt_st = M_LOW;
                end
            end
            M_LOW:
            begin
                // low phase never lengthened, so the stretch count keeps its value
                if (half_cnt_ff == 8'h00)
                    nxt_sda_oe = bit_cnt_ff[3] ? 1'b0 : !shift_ff[7];
                if (half_end)
                begin
                    nxt_half = '0;
                    nxt_scl_oe = 1'b0;
                    nxt_st = M_HIGH;
                end
            end
            M_HIGH:
            begin
                if (!scl)
                begin
                    // sync lag does not restart the high phase
                    if (half_cnt_ff >= 8'(LAG))
                        nxt_half = '0;
                    nxt_ext = ext_cnt_ff + 1'b1;
                end
                else if (half_end)
                begin
                    nxt_half = '0;
                    nxt_scl_oe = 1'b1;
                    nxt_shift = {shift_ff[6:0], 1'b0};
                    if (bit_cnt_ff[3])
                    begin
                        nxt_nack = sda;
                        nxt_st = M_STOP_LOW;
                    end
                    else
                    begin
                        nxt_bit = bit_cnt_ff + 1'b1;
                        nxt_st = M_LOW;
                    end
                end
            end
            M_STOP_LOW:
            begin
                if (half_cnt_ff == 8'h00)
                    nxt_sda_oe = 1'b1;
                if (half_end)
                begin
                    nxt_half = '0;
                    nxt_scl_oe = 1'b0;
                    nxt_st = M_STOP_HIGH;
                end
            end
            M_STOP_HIGH:
            begin
                if (!scl && half_cnt_ff >= 8'(LAG))
                    nxt_half = '0;
                else if (scl && half_end)
                begin
                    nxt_sda_oe = 1'b0;
                    nxt_st = M_IDLE;
                    mdone = 1'b1;
                end
            end
            default:
                nxt_st = M_IDLE;
        endcase
        // any abort lets go of both lines at once
        if (abort)
        begin
            nxt_st = M_IDLE;
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            mst_st_ff <= M_IDLE;
            half_cnt_ff <= '0;
            bit_cnt_ff <= '0;
            shift_ff <= '0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            nack_ff <= 1'b0;
            ext_cnt_ff <= '0;
        end
        else
        begin
            mst_st_ff <= nxt_st;
            half_cnt_ff <= nxt_half;
            bit_cnt_ff <= nxt_bit;
            shift_ff <= nxt_shift;
            scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe;
            nack_ff <= nxt_nack;
            ext_cnt_ff <= nxt_ext;
        end
    end

    assign bus_clock_line_o = 1'b0;
    assign bus_data_line_o = 1'b0;
    assign bus_clock_line_oe_o = scl_oe_ff;
    assign bus_data_line_oe_o = sda_oe_ff;

    // ****************************************
    // oscillator pick, presence, measurement
    // ****************************************
    logic [2:0] strap_cnt_ff;
    logic osc_int_ff;
    logic osc_xtal_ff;
    logic [SW-1:0] sec_cnt_ff;
    logic bias_ff;
    pack_present_input_state_e ps_ff;
    logic [2:0] fet_ff;
    logic meas_ff;
    logic [15:0] opcfg_ff;
    wire logic sec_tick = sec_cnt_ff == SW'(SEC_P - 1);
    wire logic [SW-1:0] nxt_sec = sec_tick ? '0 : sec_cnt_ff + 1'b1;
    wire logic sample_stb = bias_ff && sec_cnt_ff == SW'(BIAS_CYC - 1);
    wire logic ignore = opcfg_ff[NR_BIT];
    wire pack_present_input_state_e nxt_ps = ignore ? PS_NORMAL :
        !sample_stb ? ps_ff : pack_present_input_n ? PS_REMOVED : PS_NORMAL;

    // internal oscillator runs first; crystal only without the resistor
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            strap_cnt_ff <= '0;
            osc_int_ff <= 1'b1;
            osc_xtal_ff <= 1'b0;
        end
        else if (strap_cnt_ff != 3'(STRAP_CYC))
        begin
            strap_cnt_ff <= strap_cnt_ff + 1'b1;
            if (strap_cnt_ff == 3'(STRAP_CYC - 1))
            begin
                osc_int_ff <= osc_set_resistor_pin;
                osc_xtal_ff <= !osc_set_resistor_pin;
            end
        end
    end

    // one second frame: bias pulse at its start, state and fets follow
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            sec_cnt_ff <= SW'(SEC_P - 1); // first edge after reset opens a second
            bias_ff <= 1'b0;
            ps_ff <= PS_REMOVED;
            fet_ff <= 3'h4;
            meas_ff <= 1'b0;
        end
        else
        begin
            sec_cnt_ff <= nxt_sec;
            bias_ff <= nxt_sec < SW'(BIAS_CYC);
            ps_ff <= nxt_ps;
            fet_ff <= (nxt_ps == PS_NORMAL) ? 3'h3 : 3'h4;
            meas_ff <= sec_tick && ps_ff == PS_NORMAL;
        end
    end

    assign osc_internal_en_o = osc_int_ff;
    assign osc_crystal_en_o = osc_xtal_ff;
    assign presence_bias_output_o = bias_ff;
    assign chg_fet_en_o = fet_ff[0];
    assign dsg_fet_en_o = fet_ff[1];
    assign precharge_fet_en_o = fet_ff[2];
    assign adc_start_o = meas_ff;

    // ****************************************
    // charge counter
    // ****************************************
    logic signed [31:0] acc_ff;
    logic signed [15:0] cur_ff;
    logic chg_ff;
    logic dsg_ff;

    // signed integration of each integrator result, latched on every valid sample
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            acc_ff <= '0;
            cur_ff <= '0;
            chg_ff <= 1'b0;
            dsg_ff <= 1'b0;
        end
        else
        begin
            if (cc_valid_i)
            begin
                acc_ff <= acc_ff + 32'(cc_sample_i);
                cur_ff <= cc_sample_i;
                chg_ff <= cc_sample_i > 16'sh0000;
                dsg_ff <= cc_sample_i < 16'sh0000;
            end
        end
    end

    assign cc_charge_o = chg_ff;
    assign cc_discharge_o = dsg_ff;

    // ****************************************
    // register bus and interrupts
    // ****************************************
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [IRQ_W-1:0] sts_ff;
    logic [IRQ_W-1:0] msk_ff;
    logic irq_ff;
    logic [31:0] cur_reg;
    wire logic req = wb_cyc_i && wb_stb_i && !ack_ff;
    wire logic wr = req && wb_we_i;
    wire logic [31:0] wm = lane_mask(wb_sel_i);
    wire logic [31:0] wd = wb_dat_i & wm;
    wire logic [IRQ_W-1:0] ev = {meas_ff, nxt_ps != ps_ff, mdone,
                                 sext_hit, idle_hit, timeout_hit};
    wire logic [31:0] stat = {25'h0, wait_start_ff, in_msg_ff, osc_xtal_ff,
                              dsg_ff, chg_ff, mst_busy, ps_ff == PS_NORMAL};
    wire logic [31:0] rd =
        (wb_adr_i == A_OPCFG) ? {16'h0, opcfg_ff} :
        (wb_adr_i == A_STAT) ? stat :
        (wb_adr_i == A_ISTS) ? 32'(sts_ff) :
        (wb_adr_i == A_IMSK) ? 32'(msk_ff) :
        (wb_adr_i == A_MCTL) ? {22'h0, nack_ff, mst_busy, mbyte_ff} :
        (wb_adr_i == A_CCACC) ? acc_ff :
        (wb_adr_i == A_CUR) ? cur_reg : 32'h0;
    assign go = wr && wb_adr_i == A_MCTL && wd[MGO_BIT] && !mst_busy;
    assign cur_reg = 32'(cur_ff);

    // ack one cycle after the request, read data registered with it
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end
        else
        begin
            ack_ff <= req;
            dat_ff <= req ? rd : 32'h0;
        end
    end

    // writable registers; a new event wins over its write-one clear
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            opcfg_ff <= OPCFG_RST;
            mbyte_ff <= '0;
            sts_ff <= '0;
            msk_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            if (wr && wb_adr_i == A_OPCFG)
                opcfg_ff <= (opcfg_ff & ~wm[15:0]) | wd[15:0];
            if (go && wb_sel_i[0])
                mbyte_ff <= wd[7:0];
            if (wr && wb_adr_i == A_IMSK)
                msk_ff <= (msk_ff & ~wm[IRQ_W-1:0]) | wd[IRQ_W-1:0];
            sts_ff <= (sts_ff & ~((wr && wb_adr_i == A_ISTS) ? wd[IRQ_W-1:0] : '0)) | ev;
            irq_ff <= |(sts_ff & msk_ff);
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign irq_o = irq_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_abort;
        timeout_hit || idle_hit || sext_hit;
    endsequence
    sequence s_released;
        !scl_oe_ff && !sda_oe_ff && mst_st_ff == M_IDLE;
    endsequence

    property p_tout;
        (in_msg_ff && !scl && low_cnt_ff == TW'(TOUT_P)) |=> !in_msg_ff && sts_ff[I_TOUT];
    endproperty
    a_tout: assert property (p_tout) else $error("no abort on clock low timeout");
    property p_idle;
        (in_msg_ff && scl && hi_cnt_ff == IW'(IDLE_CYC) && !start_det) |=> !in_msg_ff;
    endproperty
    a_idle: assert property (p_idle) else $error("no reset on long clock high");
    property p_sext;
        (mst_st_ff == M_HIGH && ext_cnt_ff == XW'(SEXT_P)) |=> s_released ##0 sts_ff[I_SEXT];
    endproperty
    a_sext: assert property (p_sext) else $error("stretch budget not enforced");
    property p_mlow;
        mst_st_ff == M_LOW |-> half_cnt_ff < 8'(MAS_HALF_CYC);
    endproperty
    a_mlow: assert property (p_mlow) else $error("master low phase too long");
    property p_mrate;
        (mst_st_ff == M_LOW && half_end && !abort) |=> !scl_oe_ff && mst_st_ff == M_HIGH;
    endproperty
    a_mrate: assert property (p_mrate) else $error("master clock rate wrong");
    property p_bias;
        $rose(bias_ff) |-> sec_cnt_ff == '0 ##0 bias_ff [*8];
    endproperty
    a_bias: assert property (p_bias) else $error("bias pulse misplaced");
    logic pack_present_input_n_q;
    // presence level one cycle back, seen by the check after the sample
    always_ff @(posedge clk_i)
        pack_present_input_n_q <= pack_present_input_n;
    property p_pack_present_input;
        (sample_stb && !ignore) |=> ps_ff == (pack_present_input_n_q ? PS_REMOVED : PS_NORMAL) ##0
            fet_ff == (pack_present_input_n_q ? 3'h4 : 3'h3);
    endproperty
    a_pack_present_input: assert property (p_pack_present_input) else $error("presence sample not applied");
    property p_ign;
        ignore |=> ps_ff == PS_NORMAL;
    endproperty
    a_ign: assert property (p_ign) else $error("presence not ignored");
    property p_meas;
        meas_ff |-> $past(sec_tick) && $past(ps_ff) == PS_NORMAL;
    endproperty
    a_meas: assert property (p_meas) else $error("update outside second tick");
    property p_acc;
        cc_valid_i |=> acc_ff == $past(acc_ff) + 32'($past(cc_sample_i)) && chg_ff == ($past(cc_sample_i) > 0);
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator or direction wrong");
    property p_rel;
        s_abort |=> s_released ##0 (wait_start_ff || $past(start_det));
    endproperty
    a_rel: assert property (p_rel) else $error("lines not released on abort");
endmodule

// ### hw/pw_pkg.sv
// constants and types shared by the pack presence and bus watch block
package pw_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int T_TOUT_MS = 25;
    localparam int TOUT_CYC = CLK_HZ / 1000 * T_TOUT_MS;
    localparam int T_IDLE_US = 50;
    localparam int IDLE_CYC = CLK_HZ / 1_000_000 * T_IDLE_US;
    localparam int T_SEXT_MS = 25;
    localparam int SEXT_CYC = CLK_HZ / 1000 * T_SEXT_MS;
    // master clock 51.2 kHz, given in tenths of a hertz
    localparam int F_MAS_DHZ = 512_000;
    localparam int MAS_HALF_CYC = CLK_HZ / (F_MAS_DHZ / 10) / 2;
    localparam int T_SEC_MS = 1000;
    localparam int SEC_CYC = CLK_HZ / 1000 * T_SEC_MS;
    localparam int T_BIAS_US = 100;
    localparam int BIAS_CYC = CLK_HZ / 1_000_000 * T_BIAS_US;
    localparam int STRAP_CYC = 4;
    // one accumulator count is 0.65 nVh, kept in pVh
    localparam int CC_LSB_PVH = 650;
    // register byte offsets
    localparam logic [7:0] A_OPCFG = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_ISTS = 8'h08;
    localparam logic [7:0] A_IMSK = 8'h0C;
    localparam logic [7:0] A_MCTL = 8'h10;
    localparam logic [7:0] A_CCACC = 8'h14;
    localparam logic [7:0] A_CUR = 8'h18;
    localparam logic [15:0] OPCFG_RST = 16'h6140;
    localparam int NR_BIT = 3;
    localparam int MGO_BIT = 8;
    // interrupt status bits
    localparam int IRQ_W = 6;
    localparam int I_TOUT = 0;
    localparam int I_IDLE = 1;
    localparam int I_SEXT = 2;
    localparam int I_MDONE = 3;
    localparam int I_PACK_PRESENT_INPUT = 4;
    localparam int I_MEAS = 5;
    typedef enum logic {PS_REMOVED, PS_NORMAL} pack_present_input_state_e;
    typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_LOW, M_STOP_HIGH} mst_state_e;
endpackage

// ### tb/smbus_host_model.sv
// smbus host controller model on the far side of the bus watch
`timescale 1ns/1ps
module smbus_host_model (
    input wire logic frame_i,
    input wire logic stop_i,
    input wire logic hold_i,
    input wire logic dev_clk_oe_i,
    input wire logic dev_dat_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic clk_low = 1'b0;
    logic dat_low = 1'b0;
    // open-drain wires with pull-ups, low when any party pulls
    assign scl_o = !(clk_low | hold_i | dev_clk_oe_i);
    assign sda_o = !(dat_low | dev_dat_oe_i);
    // start, nine 400 ns clocks, then a stop or a clock left high
    always @(posedge frame_i)
    begin
        dat_low = 1'b1;
        #400;
        repeat (9)
        begin
            clk_low = 1'b1;
            #100 dat_low = !dat_low;
            #100 clk_low = 1'b0;
            wait (scl_o);
            #200;
        end
        if (stop_i)
        begin
            clk_low = 1'b1;
            dat_low = 1'b1;
            #200 clk_low = 1'b0;
            #200 dat_low = 1'b0;
        end
    end
endmodule

// ### tb/testbench.sv
// self-checking bench for the pack presence and bus watch block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, a, b); end end
`define WAIT(c) for (int k = 0; k < 9000 && !(c); k++) @(posedge clk_i);
module testbench;
    import pw_pkg::*;
    localparam int SEC = 3000;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic we = 1'b0;
    logic stb = 1'b0;
    logic pack_present_input_n = 1'b1;
    logic signed [15:0] cc_s = 16'sh0;
    logic cc_v = 1'b0;
    logic frame = 1'b0;
    logic stop = 1'b1;
    logic hold = 1'b0;
    logic osc_set_resistor_pin = 1'b0;
    logic scl, sda, ack, irq, scl_oe, sda_oe, bias, chg, dsg, pre, adc, cchg, cdsg, oi, ox;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc_n = 0;
    pack_presence_and_bus_watch #(.TOUT_P(300), .SEXT_P(200), .SEC_P(SEC))
    pack_presence_and_bus_watch_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(dat_o),
        .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_ack_o(ack),
        .irq_o(irq), .bus_clock_line_i(scl), .bus_clock_line_o(),
        .bus_clock_line_oe_o(scl_oe), .bus_data_line_i(sda), .bus_data_line_o(),
        .bus_data_line_oe_o(sda_oe), .pack_present_input_n_i(pack_present_input_n),
        .presence_bias_output_o(bias), .osc_set_resistor_pin_i(osc_set_resistor_pin),
        .osc_internal_en_o(oi), .osc_crystal_en_o(ox), .chg_fet_en_o(chg),
        .dsg_fet_en_o(dsg), .precharge_fet_en_o(pre), .cc_sample_i(cc_s),
        .cc_valid_i(cc_v), .adc_start_o(adc), .cc_charge_o(cchg), .cc_discharge_o(cdsg));
    smbus_host_model smbus_host_model_inst (.frame_i(frame), .stop_i(stop), .hold_i(hold),
        .dev_clk_oe_i(scl_oe), .dev_dat_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    always #25 clk_i = !clk_i;
    // hang guard
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 60000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // classic wishbone single cycle, held until ack
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wd <= d;
        stb <= 1'b1;
        for (n = 0; ack !== 1'b1; n++) @(posedge clk_i);
        rd = dat_o;
        stb <= 1'b0;
    endtask
    // one host frame, with or without stop
    task automatic frm(input logic s);
        @(posedge clk_i);
        stop <= s;
        frame <= 1'b1;
        @(posedge clk_i);
        frame <= 1'b0;
    endtask
    task automatic t_reset(input logic [1:0] e);
        `CHK({oi, ox, pre, scl_oe, sda_oe}, 5'h14)
        wb(A_OPCFG, 1'b0, 32'h0);
        `CHK(rd, {16'h0, OPCFG_RST})
        repeat (2) @(posedge clk_i);
        `CHK({oi, ox}, e)
        wb(8'h1C, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
    endtask
    // integrator samples: +1000 then -3000 counts
    task automatic t_cc(input logic signed [15:0] v, input logic [1:0] e);
        @(posedge clk_i);
        cc_s <= v;
        cc_v <= 1'b1;
        @(posedge clk_i);
        cc_v <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK({cchg, cdsg}, e)
    endtask
    task automatic t_pack_present_input();
        int n;
        int m = 0;
        wb(A_IMSK, 1'b1, 32'h10);
        `WAIT(bias !== 1'b1)
        pack_present_input_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(chg, 1'b0)
        `WAIT(bias === 1'b1)
        for (n = 0; bias === 1'b1; n++) @(posedge clk_i);
        `CHK(n, 2000)
        for (n = 0; bias !== 1'b1; n++) @(posedge clk_i);
        `CHK(n, SEC - 2000)
        `CHK({chg, dsg, pre, irq}, 4'hD)
        wb(A_STAT, 1'b0, 32'h0);
        `CHK(rd[0], 1'b1)
        wb(A_ISTS, 1'b1, 32'h10);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        repeat (SEC) @(posedge clk_i) m += adc;
        `CHK(m, 1)
        pack_present_input_n <= 1'b1;
        `WAIT(bias === 1'b1)
        `WAIT(bias !== 1'b1)
        repeat (2) @(posedge clk_i);
        `CHK({chg, dsg, pre}, 3'b001)
        wb(A_OPCFG, 1'b1, 32'h6148);
        repeat (3) @(posedge clk_i);
        `CHK({chg, pre}, 2'b10)
        wb(A_OPCFG, 1'b1, 32'h6140);
    endtask
    task automatic t_watch();
        wb(A_IMSK, 1'b1, 32'h0);
        wb(A_ISTS, 1'b1, 32'h3F);
        frm(1'b0);
        repeat (1300) @(posedge clk_i);
        wb(A_ISTS, 1'b0, 32'h0);
        `CHK({irq, rd[I_IDLE], rd[I_TOUT]}, 3'b010)
        wb(A_ISTS, 1'b1, 32'h3F);
        frm(1'b0);
        repeat (100) @(posedge clk_i);
        hold <= 1'b1;
        repeat (400) @(posedge clk_i);
        `CHK({scl_oe, sda_oe}, 2'b00)
        wb(A_ISTS, 1'b0, 32'h0);
        `CHK(rd[I_TOUT], 1'b1)
        wb(A_STAT, 1'b0, 32'h0);
        `CHK(rd[6], 1'b1)
        hold <= 1'b0;
    endtask
    task automatic t_master();
        int n;
        wb(A_MCTL, 1'b1, 32'h1A5);
        `WAIT(scl_oe === 1'b1)
        for (n = 0; scl_oe === 1'b1; n++) @(posedge clk_i);
        `CHK(n, MAS_HALF_CYC)
        for (n = 0; scl_oe !== 1'b1; n++) @(posedge clk_i);
        `CHK(n, MAS_HALF_CYC)
        repeat (4500) @(posedge clk_i);
        wb(A_MCTL, 1'b0, 32'h0);
        `CHK(rd[9:0], 10'h2A5)
        wb(A_MCTL, 1'b1, 32'h1A5);
        `WAIT(scl_oe === 1'b1)
        `WAIT(scl_oe !== 1'b1)
        hold <= 1'b1;
        repeat (260) @(posedge clk_i);
        `CHK({scl_oe, sda_oe}, 2'b00)
        wb(A_ISTS, 1'b0, 32'h0);
        `CHK(rd[I_SEXT], 1'b1)
        hold <= 1'b0;
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_reset(2'b01);
        t_cc(16'sh03E8, 2'b10);
        t_cc(16'shF448, 2'b01);
        wb(A_CCACC, 1'b0, 32'h0);
        `CHK(rd, 32'hFFFFF830)
        wb(A_CUR, 1'b0, 32'h0);
        `CHK(rd, 32'hFFFFF448)
        t_pack_present_input();
        t_watch();
        t_master();
        // mid-run reset with the setting resistor fitted
        wb(A_OPCFG, 1'b1, 32'h6148);
        osc_set_resistor_pin <= 1'b1;
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_reset(2'b10);
        print_verdict();
    end
endmodule
